// ===== rtl/pef_phy_event_flags.v
// per-port phy event flags, enable mask, cable length register and interrupt request
`timescale 1ns/10ps
`default_nettype none
`include "pef_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - cable length estimate sits in bits 15:12, resets to zero.
// - estimate valid only on 100BASE-TX link without open or short.
// - no estimate given while the link runs 10BASE-T.
// - flags latch high on enabled events; software cannot write them.
// - reading the source register clears all flags; flags reset to zero.
// - bit 9 latches on link coming up.
// - bit 8 latches on wake-on-LAN event.
// - bit 7 latches when energy present status becomes set.
// - bit 6 latches on auto-negotiation completion.
// - bit 5 latches on remote fault detection.
// - bit 4 latches on link going down.
// - bit 3 latches on link partner acknowledge.
// - bit 2 latches on parallel detection fault.
// - bit 1 latches on page received; bits 15:10 and 0 reserved.
// - mask bits 9..1 enable the matching flag; reset to zero.
// - mask bits 15:10 and 0 reserved, read-only.
module pef_phy_event_flags (
	input  wire        clk_in,
	input  wire        rst_in,
	// register port
	input  wire [4:0]  reg_addr_in,
	input  wire [15:0] reg_wdata_in,
	input  wire        reg_wr_in,
	input  wire        reg_rd_in,
	output reg  [15:0] reg_rdata_out,
	// link-side status, same clock
	input  wire        link_status_in,
	input  wire        wake_event_in,
	input  wire        energy_present_status_in,
	input  wire        autoneg_done_in,
	input  wire        remote_fault_in,
	input  wire        partner_ack_in,
	input  wire        parallel_detect_fault_in,
	input  wire        page_received_in,
	input  wire [2:0]  link_speed_in,
	input  wire        cable_fault_in,
	input  wire [3:0]  cable_length_meas_in,
	// interrupt
	output wire        phy_irq_out
);

	////////////////////////////////////////////////////////////////////////////
	// state
	wire [8:0]  event_flags;
	wire [8:0]  event_enable;
	reg  [3:0]  cable_length_estimate_r;
	reg  [3:0]  cable_length_estimate_nxt;
	wire [8:0]  event_hits;
	wire        link_rise;
	wire        link_fall;
	wire        energy_rise;
	wire        autoneg_rise;
	wire        rd_src;
	wire        wr_mask;
	wire        is_100tx;

	////////////////////////////////////////////////////////////////////////////
	// level sources become one-cycle edges; history resets low, so no false fall
	pef_edge_detect #(
		.RISING (1)
	) i_link_up_edge (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.level_in (link_status_in),
		.edge_out (link_rise)
	);

	pef_edge_detect #(
		.RISING (0)
	) i_link_down_edge (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.level_in (link_status_in),
		.edge_out (link_fall)
	);

	pef_edge_detect #(
		.RISING (1)
	) i_energy_edge (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.level_in (energy_present_status_in),
		.edge_out (energy_rise)
	);

	pef_edge_detect #(
		.RISING (1)
	) i_autoneg_edge (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.level_in (autoneg_done_in),
		.edge_out (autoneg_rise)
	);

	// edges and pulses onto flag positions; pulses count once per high cycle
	assign event_hits[`PEF_EV_LINK_UP]      = link_rise;
	assign event_hits[`PEF_EV_WAKE]         = wake_event_in;
	assign event_hits[`PEF_EV_ENERGY]       = energy_rise;
	assign event_hits[`PEF_EV_AN_DONE]      = autoneg_rise;
	assign event_hits[`PEF_EV_REMOTE_FAULT] = remote_fault_in;
	assign event_hits[`PEF_EV_LINK_DOWN]    = link_fall;
	assign event_hits[`PEF_EV_PARTNER_ACK]  = partner_ack_in;
	assign event_hits[`PEF_EV_PD_FAULT]     = parallel_detect_fault_in;
	assign event_hits[`PEF_EV_PAGE_RX]      = page_received_in;

	// register strobes decoded once, shared by every flag and enable bit
	assign rd_src  = reg_rd_in & (reg_addr_in == `PEF_ADDR_EVENT_SRC);
	assign wr_mask = reg_wr_in & (reg_addr_in == `PEF_ADDR_EVENT_MASK);

	////////////////////////////////////////////////////////////////////////////
	// one sticky flag per event; a clearing read loses to a same-cycle event
	pef_event_latch i_link_up_flag (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.hit_in    (event_hits[`PEF_EV_LINK_UP]),
		.enable_in (event_enable[`PEF_EV_LINK_UP]),
		.clear_in  (rd_src),
		.flag_out  (event_flags[`PEF_EV_LINK_UP])
	);
	pef_event_latch i_wake_event_flag (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.hit_in    (event_hits[`PEF_EV_WAKE]),
		.enable_in (event_enable[`PEF_EV_WAKE]),
		.clear_in  (rd_src),
		.flag_out  (event_flags[`PEF_EV_WAKE])
	);
	pef_event_latch i_energy_detect_flag (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.hit_in    (event_hits[`PEF_EV_ENERGY]),
		.enable_in (event_enable[`PEF_EV_ENERGY]),
		.clear_in  (rd_src),
		.flag_out  (event_flags[`PEF_EV_ENERGY])
	);
	pef_event_latch i_autoneg_done_flag (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.hit_in    (event_hits[`PEF_EV_AN_DONE]),
		.enable_in (event_enable[`PEF_EV_AN_DONE]),
		.clear_in  (rd_src),
		.flag_out  (event_flags[`PEF_EV_AN_DONE])
	);
	pef_event_latch i_remote_fault_flag (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.hit_in    (event_hits[`PEF_EV_REMOTE_FAULT]),
		.enable_in (event_enable[`PEF_EV_REMOTE_FAULT]),
		.clear_in  (rd_src),
		.flag_out  (event_flags[`PEF_EV_REMOTE_FAULT])
	);
	pef_event_latch i_link_down_flag (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.hit_in    (event_hits[`PEF_EV_LINK_DOWN]),
		.enable_in (event_enable[`PEF_EV_LINK_DOWN]),
		.clear_in  (rd_src),
		.flag_out  (event_flags[`PEF_EV_LINK_DOWN])
	);
	pef_event_latch i_partner_ack_flag (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.hit_in    (event_hits[`PEF_EV_PARTNER_ACK]),
		.enable_in (event_enable[`PEF_EV_PARTNER_ACK]),
		.clear_in  (rd_src),
		.flag_out  (event_flags[`PEF_EV_PARTNER_ACK])
	);
	pef_event_latch i_parallel_detect_fault_flag (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.hit_in    (event_hits[`PEF_EV_PD_FAULT]),
		.enable_in (event_enable[`PEF_EV_PD_FAULT]),
		.clear_in  (rd_src),
		.flag_out  (event_flags[`PEF_EV_PD_FAULT])
	);
	pef_event_latch i_page_received_flag (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.hit_in    (event_hits[`PEF_EV_PAGE_RX]),
		.enable_in (event_enable[`PEF_EV_PAGE_RX]),
		.clear_in  (rd_src),
		.flag_out  (event_flags[`PEF_EV_PAGE_RX])
	);

	////////////////////////////////////////////////////////////////////////////
	// mask register: only bits 9..1 are stored, the reserved bits read as zero
	pef_enable_bit i_link_up_enable (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.wr_in      (wr_mask),
		.wdata_in   (reg_wdata_in[`PEF_EV_LINK_UP + `PEF_EVT_LSB]),
		.enable_out (event_enable[`PEF_EV_LINK_UP])
	);
	pef_enable_bit i_wake_event_enable (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.wr_in      (wr_mask),
		.wdata_in   (reg_wdata_in[`PEF_EV_WAKE + `PEF_EVT_LSB]),
		.enable_out (event_enable[`PEF_EV_WAKE])
	);
	pef_enable_bit i_energy_detect_enable (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.wr_in      (wr_mask),
		.wdata_in   (reg_wdata_in[`PEF_EV_ENERGY + `PEF_EVT_LSB]),
		.enable_out (event_enable[`PEF_EV_ENERGY])
	);
	pef_enable_bit i_autoneg_done_enable (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.wr_in      (wr_mask),
		.wdata_in   (reg_wdata_in[`PEF_EV_AN_DONE + `PEF_EVT_LSB]),
		.enable_out (event_enable[`PEF_EV_AN_DONE])
	);
	pef_enable_bit i_remote_fault_enable (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.wr_in      (wr_mask),
		.wdata_in   (reg_wdata_in[`PEF_EV_REMOTE_FAULT + `PEF_EVT_LSB]),
		.enable_out (event_enable[`PEF_EV_REMOTE_FAULT])
	);
	pef_enable_bit i_link_down_enable (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.wr_in      (wr_mask),
		.wdata_in   (reg_wdata_in[`PEF_EV_LINK_DOWN + `PEF_EVT_LSB]),
		.enable_out (event_enable[`PEF_EV_LINK_DOWN])
	);
	pef_enable_bit i_partner_ack_enable (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.wr_in      (wr_mask),
		.wdata_in   (reg_wdata_in[`PEF_EV_PARTNER_ACK + `PEF_EVT_LSB]),
		.enable_out (event_enable[`PEF_EV_PARTNER_ACK])
	);
	pef_enable_bit i_parallel_detect_fault_enable (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.wr_in      (wr_mask),
		.wdata_in   (reg_wdata_in[`PEF_EV_PD_FAULT + `PEF_EVT_LSB]),
		.enable_out (event_enable[`PEF_EV_PD_FAULT])
	);
	pef_enable_bit i_page_received_enable (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.wr_in      (wr_mask),
		.wdata_in   (reg_wdata_in[`PEF_EV_PAGE_RX + `PEF_EVT_LSB]),
		.enable_out (event_enable[`PEF_EV_PAGE_RX])
	);

	////////////////////////////////////////////////////////////////////////////
	// cable length estimate: held at zero unless a clean 100BASE-TX link
	assign is_100tx = (link_speed_in == `PEF_SPD_100_HD) | (link_speed_in == `PEF_SPD_100_FD);

	always @* begin
		cable_length_estimate_nxt = `PEF_CBL_RESET;
		if (link_status_in && is_100tx && !cable_fault_in) begin
			cable_length_estimate_nxt = cable_length_meas_in;
		end
	end

	// writes to the low reserved bits are accepted and dropped
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cable_length_estimate_r <= `PEF_CBL_RESET;
		end else begin
			cable_length_estimate_r <= cable_length_estimate_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe; unmapped reads return zero
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`PEF_ADDR_CABLE_LEN:  reg_rdata_out <= {cable_length_estimate_r, `PEF_CBL_LOW_READ};
				`PEF_ADDR_EVENT_SRC:  reg_rdata_out <= {6'h00, event_flags, 1'b0};
				`PEF_ADDR_EVENT_MASK: reg_rdata_out <= {6'h00, event_enable, 1'b0};
				default:              reg_rdata_out <= 16'h0000;
			endcase
		end else begin
			reg_rdata_out <= 16'h0000;
		end
	end

	// level interrupt; flags only set when enabled so gating again covers a later mask
	assign phy_irq_out = |(event_flags & event_enable);

endmodule // pef_phy_event_flags

////////////////////////////////////////////////////////////////////////////////
// edge finder for a level that shares the block clock
module pef_edge_detect #(
	parameter RISING = 1
) (
	input  wire clk_in,
	input  wire rst_in,
	input  wire level_in,
	output wire edge_out
);

	reg level_d_r;

	// history of the level, one clock old
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			level_d_r <= 1'b0;
		end else begin
			level_d_r <= level_in;
		end
	end

	// pulse lasts exactly one clock, so a latch sees each change once
	assign edge_out = (RISING != 0) ? (level_in & ~level_d_r) : (~level_in & level_d_r);

endmodule // pef_edge_detect

////////////////////////////////////////////////////////////////////////////////
// one sticky event flag with enable gate and clear on read
module pef_event_latch (
	input  wire clk_in,
	input  wire rst_in,
	input  wire hit_in,
	input  wire enable_in,
	input  wire clear_in,
	output wire flag_out
);

	reg flag_r;
	reg flag_nxt;

	// a hit while masked is dropped for good; set beats a same-cycle clear
	always @* begin
		flag_nxt = flag_r;
		if (clear_in) begin
			flag_nxt = 1'b0;
		end
		if (hit_in && enable_in) begin
			flag_nxt = 1'b1;
		end
	end

	// no write path reaches the flag
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	assign flag_out = flag_r;

endmodule // pef_event_latch

////////////////////////////////////////////////////////////////////////////////
// one read/write enable bit of the mask register
module pef_enable_bit (
	input  wire clk_in,
	input  wire rst_in,
	input  wire wr_in,
	input  wire wdata_in,
	output wire enable_out
);

	reg enable_r;

	// bit holds until the next mask write
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			enable_r <= 1'b0;
		end else if (wr_in) begin
			enable_r <= wdata_in;
		end
	end

	assign enable_out = enable_r;

endmodule // pef_enable_bit
`default_nettype wire

// ===== rtl/pef_defs.vh
// register offsets, field positions and reset values of the phy event flag block
`ifndef PEF_DEFS_VH
`define PEF_DEFS_VH

// register indices on the management port
`define PEF_ADDR_CABLE_LEN     5'h1c
`define PEF_ADDR_EVENT_SRC     5'h1d
`define PEF_ADDR_EVENT_MASK    5'h1e

// cable length field
`define PEF_CBL_MSB            15
`define PEF_CBL_LSB            12
`define PEF_CBL_RESET          4'h0
`define PEF_CBL_LOW_READ       12'h000

// event flag field, bits 9 down to 1
`define PEF_EVT_MSB            9
`define PEF_EVT_LSB            1
`define PEF_EVT_RESET          9'h000
`define PEF_MASK_RESET         9'h000

// event bit positions inside the 9-bit field (register bit minus one)
`define PEF_EV_LINK_UP         8
`define PEF_EV_WAKE            7
`define PEF_EV_ENERGY          6
`define PEF_EV_AN_DONE         5
`define PEF_EV_REMOTE_FAULT    4
`define PEF_EV_LINK_DOWN       3
`define PEF_EV_PARTNER_ACK     2
`define PEF_EV_PD_FAULT        1
`define PEF_EV_PAGE_RX         0

// link speed codes from the speed indication field
`define PEF_SPD_100_HD         3'h2
`define PEF_SPD_100_FD         3'h6

`endif

// ===== sim/pef_monitor.sv
// port assertions for the phy event flag block
`timescale 1ns/10ps
`default_nettype none
`include "pef_defs.vh"
module pef_monitor (
	input wire logic        clk_in, rst_in, reg_rd_in, reg_wr_in, link_status_in, cable_fault_in, phy_irq_out,
	input wire logic        wake_event_in, remote_fault_in, partner_ack_in, parallel_detect_fault_in,
	input wire logic        page_received_in, energy_present_status_in, autoneg_done_in,
	input wire logic [4:0]  reg_addr_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic [2:0]  link_speed_in,
	input wire logic [3:0]  cable_length_meas_in
);
	// read strobes per register
	wire rc = reg_rd_in && reg_addr_in == `PEF_ADDR_CABLE_LEN;
	wire rs = reg_rd_in && reg_addr_in == `PEF_ADDR_EVENT_SRC;
	wire rm = reg_rd_in && reg_addr_in == `PEF_ADDR_EVENT_MASK;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////////////////////////////////////////////
	// inputs held steady so the one-cycle estimate lag cannot matter
	property p_est; rc && link_status_in && link_speed_in == `PEF_SPD_100_FD && !cable_fault_in &&
		$stable({link_status_in, link_speed_in, cable_fault_in, cable_length_meas_in})
		|=> reg_rdata_out[15:12] == $past(cable_length_meas_in); endproperty
	a_est: assert property (p_est) else $error("cable estimate wrong");
	property p_flt; rc && cable_fault_in && $past(cable_fault_in) |=> reg_rdata_out[15:12] == 4'h0; endproperty
	a_flt: assert property (p_flt) else $error("estimate shown on faulty cable");
	property p_ten; rc && link_speed_in == 3'h1 && $past(link_speed_in) == 3'h1 |=> reg_rdata_out[15:12] == 4'h0; endproperty
	a_ten: assert property (p_ten) else $error("estimate shown on 10 mbit link");
	property p_low; rc |=> reg_rdata_out[11:0] == `PEF_CBL_LOW_READ; endproperty
	a_low: assert property (p_low) else $error("cable low bits not zero");
	property p_sticky; phy_irq_out && !rs && !reg_wr_in |=> phy_irq_out; endproperty
	a_sticky: assert property (p_sticky) else $error("irq dropped without clearing read");
	property p_clr; rs && $stable({link_status_in, energy_present_status_in, autoneg_done_in}) &&
		{wake_event_in, remote_fault_in, partner_ack_in, parallel_detect_fault_in, page_received_in} == 5'h00
		|=> !phy_irq_out; endproperty
	a_clr: assert property (p_clr) else $error("irq kept after source read");
	property p_srsv; rs |=> reg_rdata_out[15:10] == 6'h00 && !reg_rdata_out[0]; endproperty
	a_srsv: assert property (p_srsv) else $error("source reserved bits set");
	property p_mrsv; rm |=> reg_rdata_out[15:10] == 6'h00 && !reg_rdata_out[0]; endproperty
	a_mrsv: assert property (p_mrsv) else $error("mask reserved bits set");
endmodule // pef_monitor
`default_nettype wire

// ===== sim/pef_host_model.sv
// management host model driving the register port
`timescale 1ns/10ps
`default_nettype none
`include "pef_defs.vh"
module pef_host_model (
	input wire logic        clk_in,
	input wire logic [15:0] rdata_in,
	output logic [4:0]      addr_out,
	output logic [15:0]     wdata_out,
	output logic            wr_out,
	output logic            rd_out
);
	initial {addr_out, wdata_out, wr_out, rd_out} = '0;
	// one-cycle write; cable register always gets the fixed low pattern
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_in) {addr_out, wr_out} <= {a, 1'b1};
		wdata_out <= (a == `PEF_ADDR_CABLE_LEN) ? {d[15:12], 12'h800} : d;
		@(posedge clk_in) wr_out <= 1'b0;
	endtask
	// data stand one cycle only, so sample at that very edge
	task rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk_in) {addr_out, rd_out} <= {a, 1'b1};
		@(posedge clk_in) rd_out <= 1'b0;
		@(posedge clk_in) d = rdata_in;
	endtask
endmodule // pef_host_model
`default_nettype wire

// ===== sim/pef_phy_event_flags_tb.sv
// self-checking bench for the phy event flag block
`timescale 1ns/10ps
`default_nettype none
`include "pef_defs.vh"
module pef_phy_event_flags_tb;
	logic clk_in = 0, rst_in = 1, wr, rd, irq, link = 0, flt = 0;
	logic [8:0] evv = '0;
	logic [4:0] addr;
	logic [15:0] wd, rdat, v;
	logic [2:0] spd = '0;
	logic [3:0] meas = '0;
	int bad_count = 0, samples_checked = 0;
	always #12.5 clk_in = ~clk_in;
	pef_host_model i_pef_host_model (.clk_in, .rdata_in(rdat), .addr_out(addr), .wdata_out(wd), .wr_out(wr), .rd_out(rd));
	pef_phy_event_flags i_pef_phy_event_flags (.clk_in, .rst_in, .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdat), .link_status_in(link), .wake_event_in(evv[7]),
		.energy_present_status_in(evv[6]), .autoneg_done_in(evv[5]), .remote_fault_in(evv[4]),
		.partner_ack_in(evv[2]), .parallel_detect_fault_in(evv[1]), .page_received_in(evv[0]),
		.link_speed_in(spd), .cable_fault_in(flt), .cable_length_meas_in(meas), .phy_irq_out(irq));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [15:0] s, e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task rchk(input logic [4:0] a, input logic [15:0] e);
		i_pef_host_model.rd(a, v);
		chk("rdata", v, e);
	endtask
	// one event of flag bit k; link is a level, the rest pulse for a cycle
	task ev(input int k);
		@(posedge clk_in) evv <= 9'h1 << (k - 1);
		link <= (k == 9) || (link && k != 4);
		@(posedge clk_in) evv <= '0;
		@(negedge clk_in);
	endtask
	task report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// watchdog far beyond the 104 or so cycles the tests need
	initial begin
		#50000;
		bad_count++;
		report_and_stop;
	end
	initial begin
		repeat (3) @(posedge clk_in);
		rst_in <= 0;
		rchk(`PEF_ADDR_CABLE_LEN, 16'h0000);
		rchk(`PEF_ADDR_EVENT_MASK, 16'h0000);
		for (int k = 9; k > 0; k--) ev(k);
		i_pef_host_model.wr(`PEF_ADDR_EVENT_MASK, 16'hffff);
		rchk(`PEF_ADDR_EVENT_SRC, 16'h0000);
		rchk(`PEF_ADDR_EVENT_MASK, 16'h03fe);
		for (int k = 9; k > 0; k--) begin
			ev(k);
			chk("irq", 16'(irq), 16'h0001);
			rchk(`PEF_ADDR_EVENT_SRC, 16'h0001 << k);
			chk("irq", 16'(irq), 16'h0000);
		end
		ev(1);
		i_pef_host_model.wr(`PEF_ADDR_EVENT_SRC, 16'h0000);
		rchk(`PEF_ADDR_EVENT_SRC, 16'h0002);
		rchk(`PEF_ADDR_EVENT_SRC, 16'h0000);
		{link, spd, meas} <= {1'b1, `PEF_SPD_100_FD, 4'ha};
		i_pef_host_model.wr(`PEF_ADDR_CABLE_LEN, 16'h0000);
		rchk(`PEF_ADDR_CABLE_LEN, 16'ha000);
		spd <= 3'h1;
		rchk(`PEF_ADDR_CABLE_LEN, 16'h0000);
		{spd, flt} <= {`PEF_SPD_100_HD, 1'b1};
		rchk(`PEF_ADDR_CABLE_LEN, 16'h0000);
		rchk(5'h00, 16'h0000);
		report_and_stop;
	end
endmodule // pef_phy_event_flags_tb
bind pef_phy_event_flags pef_monitor i_pef_monitor (.*);
`default_nettype wire
